/* File: include/isl_defines.vh */
`ifndef ISL_DEFINES_VH
`define ISL_DEFINES_VH
// Ten-bit address header pattern
`define ISL_TEN_BIT_HDR 5'h1E
// General call address byte
`define ISL_GEN_CALL_ADDR 8'h00
// Bits in a byte on the wire
`define ISL_BYTE_BITS 4'h8
// Bit count that marks the acknowledge slot
`define ISL_ACK_SLOT 4'h9
// Reset value of the clock release bit
`define ISL_CLK_REL_RESET 1'b1
`endif

/* File: rtl/isl_slave.v */
`timescale 1ns/1ps
`default_nettype none
`include "isl_defines.vh"
module isl_slave (
   // Clock and reset
   input wire mclk_in,
   input wire rstn_in,
   // Configuration
   input wire module_enable_in,
   input wire ten_bit_address_select_in,
   input wire [9:0] own_slave_address_in,
   input wire stretch_enable_in,
   input wire general_call_enable_in,
   input wire accept_all_addresses_enable_in,
   input wire slew_limit_disable_in,
   // Software access
   input wire [7:0] transmit_data_in,
   input wire transmit_write_in,
   input wire receive_read_in,
   input wire overflow_clear_in,
   input wire clock_release_set_in,
   input wire clock_release_clear_in,
   // Status
   output reg [7:0] receive_buffer_out,
   output reg receive_buffer_full_out,
   output reg transmit_buffer_full_out,
   output reg receive_overflow_out,
   output reg clock_release_out,
   output reg ten_bit_full_match_out,
   output reg transmit_mode_out,
   output reg slave_event_flag_out,
   output reg master_event_flag_out,
   output reg slew_limit_disable_out,
   // Bus pins, enable low while driving
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe_n_out,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n_out
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ADDR2 = 3'h2;
   localparam ST_RX = 3'h3;
   localparam ST_TX = 3'h4;
   localparam ST_ACK = 3'h5;
   localparam ST_TXACK = 3'h6;

   function seven_match;
      input [7:0] sh;
      input [9:0] adr;
      begin
         seven_match = (sh[7:1] == adr[6:0]);
      end
   endfunction

   // ----------------------------------------
   // Synchronisers and edges
   // ----------------------------------------
   reg scl_s1_q, scl_s2_q, scl_s3_q;
   reg sda_s1_q, sda_s2_q, sda_s3_q;
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end else begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end
   wire scl_rise = scl_s2_q & ~scl_s3_q;
   wire scl_fall = ~scl_s2_q & scl_s3_q;
   wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   wire stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   reg [2:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] serial_shift_register_q;
   reg [7:0] tx_shift_q;
   // Holding register, so a write mid-byte waits for the next byte
   reg [7:0] tx_hold_q;
   reg ack_ok_q;
   reg gen_call_q;
   reg rx_ack_q;
   reg already_addressed_state_q;
   reg ten_hdr_q;
   reg sw_stretch_q;
   reg sda_drive_low_q;

   wire [7:0] sh_next = {serial_shift_register_q[6:0], sda_s2_q};
   wire hdr_ok = (sh_next[7:3] == `ISL_TEN_BIT_HDR) &&
      (sh_next[2:1] == own_slave_address_in[9:8]);
   // General call: all-zero byte, write direction
   wire gc_hit = general_call_enable_in && (sh_next == `ISL_GEN_CALL_ADDR);

   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         serial_shift_register_q <= 8'h00;
         tx_shift_q <= 8'hFF;
         tx_hold_q <= 8'hFF;
         ack_ok_q <= 1'b0;
         gen_call_q <= 1'b0;
         rx_ack_q <= 1'b0;
         already_addressed_state_q <= 1'b0;
         ten_hdr_q <= 1'b0;
         sw_stretch_q <= 1'b0;
         sda_drive_low_q <= 1'b0;
         receive_buffer_out <= 8'h00;
         receive_buffer_full_out <= 1'b0;
         transmit_buffer_full_out <= 1'b0;
         receive_overflow_out <= 1'b0;
         clock_release_out <= `ISL_CLK_REL_RESET;
         ten_bit_full_match_out <= 1'b0;
         transmit_mode_out <= 1'b0;
         slave_event_flag_out <= 1'b0;
         master_event_flag_out <= 1'b0;
         slew_limit_disable_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe_n_out <= 1'b1;
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else begin
         slave_event_flag_out <= 1'b0;
         master_event_flag_out <= 1'b0;
         slew_limit_disable_out <= slew_limit_disable_in;
         // Software side; hardware sets below take priority
         if (receive_read_in)
            receive_buffer_full_out <= 1'b0;
         if (overflow_clear_in)
            receive_overflow_out <= 1'b0;
         if (transmit_write_in) begin
            tx_hold_q <= transmit_data_in;
            transmit_buffer_full_out <= 1'b1;
         end
         if (clock_release_set_in)
            clock_release_out <= 1'b1;
         else if (clock_release_clear_in && stretch_enable_in) begin
            clock_release_out <= 1'b0;
            sw_stretch_q <= 1'b1;
         end
         // Software stretch waits for a sampled low SCL after a fall
         if (sw_stretch_q && !clock_release_out && scl_fall)
            sw_stretch_q <= 1'b0;
         if (clock_release_out)
            sw_stretch_q <= 1'b0;
         // Shifter runs on every rise; the states decide what it means
         if (scl_rise)
            serial_shift_register_q <= sh_next;
         if (!module_enable_in || stop_det) begin
            state_q <= ST_IDLE;
            already_addressed_state_q <= 1'b0;
            transmit_mode_out <= 1'b0;
            sda_drive_low_q <= 1'b0;
            clock_release_out <= 1'b1;
            sw_stretch_q <= 1'b0;
         end else if (start_det) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_drive_low_q <= 1'b0;
            transmit_mode_out <= 1'b0;
            ten_hdr_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_drive_low_q <= 1'b0;
               end
               ST_ADDR, ST_ADDR2, ST_RX: begin
                  if (scl_rise) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == `ISL_BYTE_BITS - 4'h1) begin
                        gen_call_q <= 1'b0;
                        ack_ok_q <= 1'b0;
                        if (state_q == ST_ADDR) begin
                           rx_ack_q <= 1'b0;
                           if (accept_all_addresses_enable_in) begin
                              ack_ok_q <= 1'b1;
                              transmit_mode_out <= sh_next[0];
                           end else if (ten_bit_address_select_in) begin
                              // Header after a repeated start with prior match
                              if (hdr_ok && (!sh_next[0] || already_addressed_state_q)) begin
                                 ack_ok_q <= 1'b1;
                                 transmit_mode_out <= sh_next[0];
                                 ten_hdr_q <= !sh_next[0];
                                 if (!sh_next[0])
                                    ten_bit_full_match_out <= 1'b0;
                              end else if (gc_hit) begin
                                 ack_ok_q <= 1'b1;
                                 gen_call_q <= 1'b1;
                              end else begin
                                 ten_bit_full_match_out <= 1'b0;
                                 state_q <= ST_IDLE;
                              end
                           end else if (seven_match(sh_next, own_slave_address_in)) begin
                              ack_ok_q <= 1'b1;
                              transmit_mode_out <= sh_next[0];
                           end else if (gc_hit) begin
                              ack_ok_q <= 1'b1;
                              gen_call_q <= 1'b1;
                           end else
                              state_q <= ST_IDLE;
                           if (gc_hit && !accept_all_addresses_enable_in) begin
                              receive_buffer_out <= sh_next;
                              receive_buffer_full_out <= 1'b1;
                           end
                        end else if (state_q == ST_ADDR2) begin
                           if (sh_next == own_slave_address_in[7:0]) begin
                              ack_ok_q <= 1'b1;
                              ten_bit_full_match_out <= 1'b1;
                              already_addressed_state_q <= 1'b1;
                           end else begin
                              ten_bit_full_match_out <= 1'b0;
                              state_q <= ST_IDLE;
                           end
                        end else begin
                           rx_ack_q <= 1'b1;
                           if (!receive_buffer_full_out) begin
                              receive_buffer_out <= sh_next;
                              receive_buffer_full_out <= 1'b1;
                              ack_ok_q <= !receive_overflow_out;
                           end else
                              receive_overflow_out <= 1'b1;
                        end
                     end
                  end
                  if (scl_fall && bit_cnt_q == `ISL_BYTE_BITS) begin
                     state_q <= ST_ACK;
                     sda_drive_low_q <= ack_ok_q;
                  end
               end
               ST_ACK: begin
                  // Ninth fall: event pulse, then the stretch decision
                  if (scl_fall) begin
                     sda_drive_low_q <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     if (gen_call_q)
                        master_event_flag_out <= 1'b1;
                     else
                        slave_event_flag_out <= 1'b1;
                     if (ten_hdr_q) begin
                        ten_hdr_q <= 1'b0;
                        state_q <= ST_ADDR2;
                        if (stretch_enable_in)
                           clock_release_out <= 1'b0;
                     end else if (transmit_mode_out && !rx_ack_q) begin
                        state_q <= ST_TX;
                        if (!transmit_buffer_full_out)
                           clock_release_out <= 1'b0;
                        sda_drive_low_q <= 1'b0;
                     end else begin
                        state_q <= ST_RX;
                        if (stretch_enable_in && (receive_buffer_full_out && !receive_read_in))
                           clock_release_out <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  // First bit set up while SCL is low, before release lets it rise
                  if (!scl_s2_q && bit_cnt_q == 4'h0 && transmit_buffer_full_out) begin
                     sda_drive_low_q <= !tx_hold_q[7];
                     tx_shift_q <= {tx_hold_q[6:0], 1'b1};
                     transmit_buffer_full_out <= transmit_write_in;
                     bit_cnt_q <= 4'h1;
                  end else if (scl_fall && bit_cnt_q != 4'h0) begin
                     if (bit_cnt_q == `ISL_BYTE_BITS) begin
                        sda_drive_low_q <= 1'b0;
                        state_q <= ST_TXACK;
                     end else begin
                        sda_drive_low_q <= !tx_shift_q[7];
                        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_TXACK: begin
                  // Master's answer taken on the ninth rise
                  if (scl_rise)
                     ack_ok_q <= !sda_s2_q;
                  if (scl_fall) begin
                     slave_event_flag_out <= 1'b1;
                     bit_cnt_q <= 4'h0;
                     if (ack_ok_q) begin
                        state_q <= ST_TX;
                        if (!transmit_buffer_full_out && !transmit_write_in)
                           clock_release_out <= 1'b0;
                     end else
                        state_q <= ST_IDLE;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
         // Pin drivers; hardware stretch at once, software only after fall
         sda_oe_n_out <= !(sda_drive_low_q && module_enable_in);
         scl_oe_n_out <= !(module_enable_in && !clock_release_out &&
            (!sw_stretch_q) && (state_q != ST_IDLE || !scl_s2_q));
      end
   end

endmodule // isl_slave
`default_nettype wire

/* File: tb/isl_mst_model.sv */
`timescale 1ns/1ps
`default_nettype none
module isl_mst_model (
   // Clock and bus lines
   input wire logic clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   // Open-drain pulls
   output var logic scl_low_out,
   output var logic sda_low_out
);
   // ----
   // Bus master
   // ----
   initial begin
      scl_low_out = 1'h0;
      sda_low_out = 1'h0;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Release SCL, wait out a stretch of up to 4000 cycles
   task automatic rise();
      int w;
      scl_low_out = 1'h0;
      w = 0;
      while (scl_in !== 1'h1 && w < 4000) begin
         hw(1);
         w++;
      end
      hw(8);
   endtask
   task automatic bit_x(input logic b, output logic s);
      sda_low_out = !b;
      hw(4);
      rise();
      s = sda_in;
      scl_low_out = 1'h1;
      hw(4);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic ab, output logic [7:0] q,
                         output logic ak);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ab, ak);
   endtask
   task automatic start();
      sda_low_out = 1'h1;
      hw(8);
      scl_low_out = 1'h1;
      hw(4);
   endtask
   // Repeated start from a low SCL, no stop in between
   task automatic rstart();
      sda_low_out = 1'h0;
      hw(4);
      rise();
      start();
   endtask
   task automatic stop();
      sda_low_out = 1'h1;
      hw(4);
      rise();
      sda_low_out = 1'h0;
      hw(8);
   endtask
endmodule // isl_mst_model
`default_nettype wire

/* File: tb/isl_slave_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module isl_slave_sva (
   // Watched ports
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic stretch_enable_in,
   input wire logic general_call_enable_in,
   input wire logic slew_limit_disable_in,
   input wire logic transmit_write_in,
   input wire logic receive_read_in,
   input wire logic clock_release_set_in,
   input wire logic clock_release_clear_in,
   input wire logic [7:0] receive_buffer_out,
   input wire logic receive_buffer_full_out,
   input wire logic transmit_buffer_full_out,
   input wire logic clock_release_out,
   input wire logic transmit_mode_out,
   input wire logic slave_event_flag_out,
   input wire logic master_event_flag_out,
   input wire logic slew_limit_disable_out,
   input wire logic scl_out,
   input wire logic scl_oe_n_out,
   input wire logic sda_out
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_held;
      !scl_oe_n_out && !clock_release_out && !clock_release_set_in;
   endsequence
   sequence s_freed;
      clock_release_out [*3];
   endsequence
   reset_idle_a: assert property ($rose(rstn_in) |-> clock_release_out && scl_oe_n_out)
      else $error("not idle after reset");
   stretch_hold_a: assert property (s_held |=> !scl_oe_n_out)
      else $error("stretch dropped early");
   stretch_free_a: assert property (s_freed |-> scl_oe_n_out)
      else $error("scl held with release set");
   clear_ignored_a: assert property (!stretch_enable_in && clock_release_out &&
      clock_release_clear_in && !transmit_mode_out |=> clock_release_out)
      else $error("release clear not ignored");
   release_set_a: assert property (clock_release_set_in |=> clock_release_out)
      else $error("release set lost");
   full_keep_a: assert property (receive_buffer_full_out && !receive_read_in |=>
      $stable(receive_buffer_out)) else $error("full buffer overwritten");
   load_flag_a: assert property ($changed(receive_buffer_out) |-> ##[0:1]
      receive_buffer_full_out) else $error("load without full flag");
   event_pulse_a: assert property (slave_event_flag_out || master_event_flag_out |=>
      !slave_event_flag_out && !master_event_flag_out) else $error("event not a pulse");
   gc_event_a: assert property (master_event_flag_out |-> general_call_enable_in)
      else $error("master event without general call");
   slew_mirror_a: assert property ($past(rstn_in) |->
      slew_limit_disable_out == $past(slew_limit_disable_in)) else $error("slew mirror wrong");
   tx_full_a: assert property (transmit_write_in |=> transmit_buffer_full_out)
      else $error("transmit full not set");
   pin_low_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
endmodule // isl_slave_sva
bind isl_slave isl_slave_sva u_sva (.mclk_in, .rstn_in, .stretch_enable_in,
   .general_call_enable_in, .slew_limit_disable_in, .transmit_write_in, .receive_read_in,
   .clock_release_set_in, .clock_release_clear_in, .receive_buffer_out, .receive_buffer_full_out,
   .transmit_buffer_full_out, .clock_release_out, .transmit_mode_out, .slave_event_flag_out,
   .master_event_flag_out, .slew_limit_disable_out, .scl_out, .scl_oe_n_out, .sda_out);
`default_nettype wire

/* File: tb/isl_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module isl_slave_tb;
   // ----
   // Bench
   // ----
   logic mclk_in = 1'h0, rstn_in = 1'h0, module_enable_in = 1'h1;
   logic ten_bit_address_select_in = 1'h0, stretch_enable_in = 1'h0;
   logic general_call_enable_in = 1'h0, accept_all_addresses_enable_in = 1'h0;
   logic slew_limit_disable_in = 1'h0, transmit_write_in = 1'h0, receive_read_in = 1'h0;
   logic overflow_clear_in = 1'h0, clock_release_set_in = 1'h0, clock_release_clear_in = 1'h0;
   logic [9:0] own_slave_address_in = 10'h052;
   logic [7:0] transmit_data_in = 8'h00, q;
   logic k, m_scl_low, m_sda_low;
   wire [7:0] receive_buffer_out;
   wire receive_buffer_full_out, transmit_buffer_full_out, receive_overflow_out;
   wire clock_release_out, ten_bit_full_match_out, transmit_mode_out, slave_event_flag_out;
   wire master_event_flag_out, slew_limit_disable_out, scl_out, scl_oe_n_out, sda_out;
   wire sda_oe_n_out, scl_in, sda_in;
   int mismatches = 0, check_count = 0, sev = 0, mev = 0, cyc = 0, n;
   assign scl_in = !m_scl_low & (scl_oe_n_out | scl_out);
   assign sda_in = !m_sda_low & (sda_oe_n_out | sda_out);
   always #5 mclk_in = !mclk_in;
   isl_slave DUT (.mclk_in, .rstn_in, .module_enable_in, .ten_bit_address_select_in,
      .own_slave_address_in, .stretch_enable_in, .general_call_enable_in,
      .accept_all_addresses_enable_in, .slew_limit_disable_in, .transmit_data_in,
      .transmit_write_in, .receive_read_in, .overflow_clear_in, .clock_release_set_in,
      .clock_release_clear_in, .receive_buffer_out, .receive_buffer_full_out,
      .transmit_buffer_full_out, .receive_overflow_out, .clock_release_out,
      .ten_bit_full_match_out, .transmit_mode_out, .slave_event_flag_out,
      .master_event_flag_out, .slew_limit_disable_out, .scl_in, .scl_out, .scl_oe_n_out,
      .sda_in, .sda_out, .sda_oe_n_out);
   isl_mst_model m (.clk_in(mclk_in), .scl_in, .sda_in, .scl_low_out(m_scl_low),
      .sda_low_out(m_sda_low));
   always @(posedge mclk_in) begin
      if (slave_event_flag_out === 1'h1) sev++;
      if (master_event_flag_out === 1'h1) mev++;
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      m.hw(1);
      s = 1'h0;
   endtask
   task automatic adr(input logic [7:0] a);
      m.start();
      m.byte_x(a, 1'h1, q, k);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk_in);
      #1;
      rstn_in = 1'h1;
      slew_limit_disable_in = 1'h1;
      m.hw(3);
      chk("slew", slew_limit_disable_out, 10'h001);
      adr(8'hA4);
      chk("adr ack", k, 10'h000);
      chk("adr full", receive_buffer_full_out, 10'h000);
      m.byte_x(8'hA5, 1'h1, q, k);
      chk("rx ack", k, 10'h000);
      chk("rx byte", receive_buffer_out, 10'h0A5);
      m.byte_x(8'h3C, 1'h1, q, k);
      chk("full nack", k, 10'h001);
      chk("ovf flag", receive_overflow_out, 10'h001);
      chk("kept", receive_buffer_out, 10'h0A5);
      m.stop();
      chk("events", 10'(sev), 10'h003);
      chk("freed", sda_oe_n_out & scl_oe_n_out, 10'h001);
      pulse(receive_read_in);
      adr(8'hA4);
      m.byte_x(8'h77, 1'h1, q, k);
      chk("ovf nack", k, 10'h001);
      chk("ovf load", receive_buffer_out, 10'h077);
      m.stop();
      pulse(overflow_clear_in);
      pulse(receive_read_in);
      adr(8'hA6);
      chk("other adr", k, 10'h001);
      m.stop();
      adr(8'hA4);
      module_enable_in = 1'h0;
      slew_limit_disable_in = 1'h0;
      m.hw(4);
      module_enable_in = 1'h1;
      m.byte_x(8'h11, 1'h1, q, k);
      chk("disabled", {k, receive_buffer_full_out}, 10'h002);
      chk("slew off", slew_limit_disable_out, 10'h000);
      m.stop();
      accept_all_addresses_enable_in = 1'h1;
      adr(8'h22);
      chk("any adr", k, 10'h000);
      m.stop();
      accept_all_addresses_enable_in = 1'h0;
      general_call_enable_in = 1'h1;
      adr(8'h00);
      chk("gc ack", k, 10'h000);
      chk("gc byte", {receive_buffer_full_out, receive_buffer_out}, 10'h100);
      m.stop();
      chk("gc event", 10'(mev), 10'h001);
      general_call_enable_in = 1'h0;
      pulse(receive_read_in);
      n = sev;
      adr(8'hA5);
      chk("tx ack", k, 10'h000);
      chk("tx mode", transmit_mode_out, 10'h001);
      m.hw(20);
      chk("tx hold", {scl_oe_n_out, clock_release_out}, 10'h000);
      fork
         m.byte_x(8'hFF, 1'h0, q, k);
         begin
            m.hw(10);
            transmit_data_in = 8'hC3;
            pulse(transmit_write_in);
            pulse(clock_release_set_in);
            m.hw(40);
            transmit_data_in = 8'h3C;
            pulse(transmit_write_in);
         end
      join
      chk("tx byte", q, 10'h0C3);
      chk("no stretch", clock_release_out, 10'h001);
      m.byte_x(8'hFF, 1'h1, q, k);
      chk("tx byte2", q, 10'h03C);
      m.stop();
      chk("tx events", 10'(sev - n), 10'h003);
      stretch_enable_in = 1'h1;
      adr(8'hA4);
      m.byte_x(8'h5A, 1'h1, q, k);
      m.hw(10);
      chk("rx hold", {scl_oe_n_out, clock_release_out}, 10'h000);
      pulse(receive_read_in);
      pulse(clock_release_set_in);
      m.hw(6);
      chk("rx free", scl_oe_n_out, 10'h001);
      m.stop();
      pulse(clock_release_clear_in);
      m.hw(10);
      chk("sw clr", {scl_oe_n_out, clock_release_out}, 10'h002);
      pulse(clock_release_set_in);
      stretch_enable_in = 1'h0;
      pulse(clock_release_clear_in);
      chk("clr ignored", clock_release_out, 10'h001);
      ten_bit_address_select_in = 1'h1;
      own_slave_address_in = 10'h2A5;
      stretch_enable_in = 1'h1;
      adr(8'hF4);
      chk("hdr", {k, ten_bit_full_match_out}, 10'h000);
      m.hw(10);
      chk("adr hold", {scl_oe_n_out, clock_release_out}, 10'h000);
      pulse(clock_release_set_in);
      m.byte_x(8'hA5, 1'h1, q, k);
      chk("low", {k, ten_bit_full_match_out}, 10'h001);
      transmit_data_in = 8'h96;
      pulse(transmit_write_in);
      m.rstart();
      m.byte_x(8'hF5, 1'h1, q, k);
      chk("rd hdr", {k, transmit_mode_out}, 10'h001);
      m.byte_x(8'hFF, 1'h1, q, k);
      chk("rd byte", q, 10'h096);
      m.stop();
      tally_and_finish();
   end
endmodule // isl_slave_tb
`default_nettype wire
